// >>> core/sdc_defines.svh
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
// Pin widths
`define SDC_BANK_W 2
`define SDC_ADDR_W 13
`define SDC_COL_W 9
`define SDC_DATA_W 16
`define SDC_LANES 2
// Address pin that carries the precharge flag
`define SDC_PRE_BIT 10
// Data mask latency on read outputs, in clocks
`define SDC_MASK_LAT 2
// Reset values
`define SDC_BANKS_RST 4'h0
`define SDC_MODE_RST 15'h0000
`endif

// >>> core/sdc_pkg.sv
/*
  Types shared by both ends of the command link.
  Assumes sdc_defines.svh is on the include path.
*/
package sdc_pkg;
  // Decoded command
  typedef enum logic [3:0] {
    SDC_DESEL, SDC_NOP, SDC_ACT, SDC_PRE, SDC_PALL, SDC_RD, SDC_WR,
    SDC_MRS, SDC_BST, SDC_REF, SDC_BAD
  } sdc_cmd_type;
  // Device power state
  typedef enum logic [1:0] {
    SDC_RUN, SDC_PDOWN, SDC_SUSP, SDC_SREF
  } sdc_pwr_type;
endpackage : sdc_pkg

// >>> core/sdc_link_if.sv
/*
  Command and data pins between controller and device.
  Assumes both ends share clk_sys; data_pins resolved here from enables.
*/
`timescale 1ns/10ps
`include "sdc_defines.svh"
interface sdc_link_if;
  logic chip_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_select_n;
  logic clock_gate_enable;
  logic [`SDC_BANK_W-1:0] bank_select;
  logic [`SDC_ADDR_W-1:0] address_pins;
  logic [`SDC_LANES-1:0] byte_lane_masks;
  logic [`SDC_DATA_W-1:0] host_dq_out;
  logic host_dq_oe;
  logic [`SDC_DATA_W-1:0] dev_dq_out;
  logic dev_dq_oe;
  logic [`SDC_DATA_W-1:0] data_pins;
  // Wire level from whichever end drives
  assign data_pins = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : '0);
  modport host (
    output chip_select_n, row_strobe_n, column_strobe_n, write_select_n,
    output clock_gate_enable, bank_select, address_pins, byte_lane_masks,
    output host_dq_out, host_dq_oe,
    input data_pins
  );
  modport device (
    input chip_select_n, row_strobe_n, column_strobe_n, write_select_n,
    input clock_gate_enable, bank_select, address_pins, byte_lane_masks,
    output dev_dq_out, dev_dq_oe,
    input data_pins
  );
endinterface : sdc_link_if

// >>> core/sdc_device.sv
/*
  Device end: samples command pins, decodes commands, tracks bank and
  power state, and moves masked data on data_pins.
  Assumes the controller runs on clk_sys and keeps its own rules.
*/
// Notes on behaviour
// - Sample pins each rising edge, decode samples
// - Chip select high means deselect
// - Column access: select low, row high, column low
// - Write select picks write or read
// - Row open or precharge by write select
// - Precharge flag picks close all or one
// - Column from nine pins, flag means autoprecharge
// - Decode mode set, no-op and burst stop
// - Gate enable judged at previous and current edge
// - Refresh or self refresh by gate enable
// - Gate enable rise with no-op or deselect leaves power-down, self refresh
// - Gate enable rise ends clock suspend
// - Gate fall during burst, or with a non-quiet command and bank active, suspends clock
// - Gate fall with no-op enters power-down
// - Burst stop honoured only during burst
// - Controller opens idle banks, accesses active ones
// - Mask blocks read drivers and write data
// - Read mask applies two clocks later
// - Data moves on rising edges, per lane mask
`timescale 1ns/10ps
`include "sdc_defines.svh"
module sdc_device #(
  parameter int DATA_W = `SDC_DATA_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sdc_link_if.device link,
  output logic [3:0] bank_active,
  output sdc_pkg::sdc_pwr_type power_state,
  output logic burst_running,
  output logic [14:0] mode_word,
  output logic [`SDC_COL_W-1:0] last_column,
  output logic auto_precharge,
  output logic [DATA_W-1:0] write_data,
  output logic [`SDC_LANES-1:0] write_lanes,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic read_valid,
  input wire logic burst_done
);
  import sdc_pkg::*;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // All pins captured on the edge; decode only looks at these copies
  logic cs_n_q, ras_n_q, cas_n_q, we_n_q, cke_q, cke_prev_q;
  logic [`SDC_BANK_W-1:0] ba_q;
  logic [`SDC_ADDR_W-1:0] a_q;
  logic [`SDC_LANES-1:0] dqm_q, dqm_d1_q;
  logic [DATA_W-1:0] dq_in_q;
  always_ff @(posedge clk_sys) begin
    cs_n_q <= link.chip_select_n;
    ras_n_q <= link.row_strobe_n;
    cas_n_q <= link.column_strobe_n;
    we_n_q <= link.write_select_n;
    cke_q <= link.clock_gate_enable;
    cke_prev_q <= cke_q;
    ba_q <= link.bank_select;
    a_q <= link.address_pins;
    dqm_q <= link.byte_lane_masks;
    dqm_d1_q <= dqm_q;
    dq_in_q <= link.data_pins;
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  sdc_cmd_type cmd;
  always_comb begin
    if (cs_n_q) begin
      cmd = SDC_DESEL;
    end else begin
      case ({ras_n_q, cas_n_q, we_n_q})
        3'b111: cmd = SDC_NOP;
        3'b011: cmd = SDC_ACT;
        3'b010: cmd = a_q[`SDC_PRE_BIT] ? SDC_PALL : SDC_PRE;
        3'b101: cmd = SDC_RD;
        3'b100: cmd = SDC_WR;
        3'b000: cmd = SDC_MRS;
        3'b110: cmd = SDC_BST;
        3'b001: cmd = SDC_REF;
        default: cmd = SDC_BAD;
      endcase
    end
  end

  // ----------------------------------------
  // Bank and power state
  // ----------------------------------------
  logic [3:0] banks_q, banks_d;
  sdc_pwr_type pwr_q, pwr_d;
  logic burst_q, burst_d, wr_burst_q, wr_burst_d, ap_q, ap_d;
  logic [14:0] mode_q, mode_d;
  logic [`SDC_COL_W-1:0] col_q, col_d;
  logic refresh_pulse;
  logic cke_fall, cke_rise, quiet, idle;
  assign cke_fall = cke_prev_q && !cke_q;
  assign cke_rise = !cke_prev_q && cke_q;
  assign quiet = (cmd == SDC_DESEL) || (cmd == SDC_NOP);
  assign idle = (banks_q == 4'h0);

  always_comb begin
    banks_d = banks_q;
    pwr_d = pwr_q;
    burst_d = burst_q && !burst_done;
    wr_burst_d = wr_burst_q && !burst_done;
    ap_d = ap_q;
    mode_d = mode_q;
    col_d = col_q;
    refresh_pulse = 1'b0;
    case (pwr_q)
      SDC_PDOWN, SDC_SREF: begin
        if (cke_rise && quiet) begin
          pwr_d = SDC_RUN;
        end
      end
      SDC_SUSP: begin
        // Internal state frozen while suspended
        burst_d = burst_q;
        wr_burst_d = wr_burst_q;
        if (cke_rise) begin
          pwr_d = SDC_RUN;
        end
      end
      default: begin
        if (cke_prev_q) begin
          if (cmd == SDC_REF && idle) begin
            if (cke_q) begin
              refresh_pulse = 1'b1;
            end else begin
              pwr_d = SDC_SREF;
            end
          end else if (!cke_q && burst_q) begin
            pwr_d = SDC_SUSP;
            burst_d = burst_q;
            wr_burst_d = wr_burst_q;
          end else if (!cke_q && quiet) begin
            pwr_d = SDC_PDOWN;
          end else if (cke_fall && !idle) begin
            pwr_d = SDC_SUSP;
            burst_d = burst_q;
            wr_burst_d = wr_burst_q;
          end else begin
            case (cmd)
              SDC_ACT: banks_d[ba_q] = 1'b1;
              SDC_PRE: banks_d[ba_q] = 1'b0;
              SDC_PALL: banks_d = 4'h0;
              SDC_MRS: begin
                if (idle) begin
                  mode_d = {ba_q, a_q};
                end
              end
              SDC_RD, SDC_WR: begin
                if (banks_q[ba_q]) begin
                  col_d = a_q[`SDC_COL_W-1:0];
                  ap_d = a_q[`SDC_PRE_BIT];
                  burst_d = 1'b1;
                  wr_burst_d = (cmd == SDC_WR);
                end
              end
              SDC_BST: begin
                if (burst_q) begin
                  burst_d = 1'b0;
                  wr_burst_d = 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      banks_q <= `SDC_BANKS_RST;
      pwr_q <= SDC_RUN;
      burst_q <= 1'b0;
      wr_burst_q <= 1'b0;
      ap_q <= 1'b0;
      mode_q <= `SDC_MODE_RST;
      col_q <= '0;
    end else begin
      banks_q <= banks_d;
      pwr_q <= pwr_d;
      burst_q <= burst_d;
      wr_burst_q <= wr_burst_d;
      ap_q <= ap_d;
      mode_q <= mode_d;
      col_q <= col_d;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  // Write data per lane; masked lanes keep old value
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [`SDC_LANES-1:0] wlanes_q, wlanes_d;
  logic [DATA_W-1:0] dq_out_q, dq_out_d;
  logic [`SDC_LANES-1:0] dq_oe_q, dq_oe_d;
  localparam int LANE_W = DATA_W / `SDC_LANES;
  always_comb begin
    wdata_d = wdata_q;
    wlanes_d = '0;
    dq_out_d = read_data;
    dq_oe_d = '0;
    for (int i = 0; i < `SDC_LANES; i++) begin
      if (wr_burst_q && !dqm_q[i] && pwr_q == SDC_RUN) begin
        wdata_d[i*LANE_W +: LANE_W] = dq_in_q[i*LANE_W +: LANE_W];
        wlanes_d[i] = 1'b1;
      end
      // Mask sampled two edges ago gates the driver now
      dq_oe_d[i] = read_valid && !wr_burst_q && !dqm_d1_q[i];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wdata_q <= '0;
      wlanes_q <= '0;
      dq_out_q <= '0;
      dq_oe_q <= '0;
    end else begin
      wdata_q <= wdata_d;
      wlanes_q <= wlanes_d;
      dq_out_q <= dq_out_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // Lanes share one enable on the link; masked lanes drive zero
  always_comb begin
    for (int i = 0; i < `SDC_LANES; i++) begin
      link.dev_dq_out[i*LANE_W +: LANE_W] = dq_oe_q[i] ? dq_out_q[i*LANE_W +: LANE_W] : '0;
    end
  end
  assign link.dev_dq_oe = |dq_oe_q;

  assign bank_active = banks_q;
  assign power_state = pwr_q;
  assign burst_running = burst_q;
  assign mode_word = mode_q;
  assign last_column = col_q;
  assign auto_precharge = ap_q;
  assign write_data = wdata_q;
  assign write_lanes = wlanes_q;
  // Refresh pulse is not an output; marks its decode point only
  logic unused_refresh;
  assign unused_refresh = refresh_pulse;
endmodule : sdc_device

// >>> core/sdc_host.sv
/*
  Controller end: drives one command per request onto the link.
  Assumes requests come from logic on clk_sys; keeps bank bookkeeping.
*/
`timescale 1ns/10ps
`include "sdc_defines.svh"
module sdc_host #(
  parameter int DATA_W = `SDC_DATA_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sdc_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire sdc_pkg::sdc_cmd_type req_cmd,
  input wire logic [`SDC_BANK_W-1:0] req_bank,
  input wire logic [`SDC_ADDR_W-1:0] req_addr,
  input wire logic req_cke,
  input wire logic [`SDC_LANES-1:0] req_mask,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_drive,
  output logic [DATA_W-1:0] rd_data
);
  import sdc_pkg::*;

  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  logic [3:0] open_q, open_d;
  logic cs_q, ras_q, cas_q, we_q, cke_q, oe_q;
  logic cs_d, ras_d, cas_d, we_d, cke_d, oe_d;
  logic [`SDC_BANK_W-1:0] ba_q, ba_d;
  logic [`SDC_ADDR_W-1:0] a_q, a_d;
  logic [`SDC_LANES-1:0] dqm_q, dqm_d;
  logic [DATA_W-1:0] dq_q, dq_d, rd_q;
  logic legal;
  // Refuse row opens to open banks and accesses to idle banks rather than put them on the pins
  always_comb begin
    case (req_cmd)
      SDC_ACT: legal = !open_q[req_bank];
      SDC_RD, SDC_WR: legal = open_q[req_bank];
      default: legal = 1'b1;
    endcase
  end
  assign req_ready = legal;

  always_comb begin
    {cs_d, ras_d, cas_d, we_d} = 4'b0111;
    cke_d = req_cke;
    ba_d = req_bank;
    a_d = req_addr;
    dqm_d = req_mask;
    dq_d = req_wdata;
    oe_d = req_drive;
    open_d = open_q;
    if (req_valid && legal) begin
      case (req_cmd)
        SDC_DESEL: {cs_d, ras_d, cas_d, we_d} = 4'b1111;
        SDC_ACT: begin
          {cs_d, ras_d, cas_d, we_d} = 4'b0011;
          open_d[req_bank] = 1'b1;
        end
        SDC_PRE: begin
          {cs_d, ras_d, cas_d, we_d} = 4'b0010;
          a_d[`SDC_PRE_BIT] = 1'b0;
          open_d[req_bank] = 1'b0;
        end
        SDC_PALL: begin
          {cs_d, ras_d, cas_d, we_d} = 4'b0010;
          a_d[`SDC_PRE_BIT] = 1'b1;
          open_d = 4'h0;
        end
        SDC_RD: {cs_d, ras_d, cas_d, we_d} = 4'b0101;
        SDC_WR: {cs_d, ras_d, cas_d, we_d} = 4'b0100;
        SDC_MRS: {cs_d, ras_d, cas_d, we_d} = 4'b0000;
        SDC_BST: {cs_d, ras_d, cas_d, we_d} = 4'b0110;
        SDC_REF: {cs_d, ras_d, cas_d, we_d} = 4'b0001;
        default: {cs_d, ras_d, cas_d, we_d} = 4'b0111;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {cs_q, ras_q, cas_q, we_q} <= 4'b1111;
      cke_q <= 1'b1;
      ba_q <= '0;
      a_q <= '0;
      dqm_q <= '1;
      dq_q <= '0;
      oe_q <= 1'b0;
      open_q <= `SDC_BANKS_RST;
      rd_q <= '0;
    end else begin
      {cs_q, ras_q, cas_q, we_q} <= {cs_d, ras_d, cas_d, we_d};
      cke_q <= cke_d;
      ba_q <= ba_d;
      a_q <= a_d;
      dqm_q <= dqm_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      open_q <= open_d;
      rd_q <= link.data_pins;
    end
  end

  assign link.chip_select_n = cs_q;
  assign link.row_strobe_n = ras_q;
  assign link.column_strobe_n = cas_q;
  assign link.write_select_n = we_q;
  assign link.clock_gate_enable = cke_q;
  assign link.bank_select = ba_q;
  assign link.address_pins = a_q;
  assign link.byte_lane_masks = dqm_q;
  assign link.host_dq_out = dq_q;
  assign link.host_dq_oe = oe_q;
  assign rd_data = rd_q;
endmodule : sdc_host

// >>> tb/sdc_monitor.sv
/*
  Checker on the link pins between controller and device.
  Assumes one clk_sys domain and sys_rst synchronous, active high.
*/
`timescale 1ns/10ps
module sdc_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_select_n,
  input wire logic clock_gate_enable,
  input wire logic [1:0] bank_select,
  input wire logic [12:0] address_pins,
  input wire logic [1:0] byte_lane_masks,
  input wire logic host_dq_oe,
  input wire logic [15:0] dev_dq_out,
  input wire logic dev_dq_oe
);
  // ----------------------------------------
  // Command patterns and wire-side bank map
  // ----------------------------------------
  logic sel;
  logic nop;
  logic act;
  logic pre;
  logic rw;
  logic mrs;
  logic rf;
  logic cke_q;
  logic cke_d;
  logic [3:0] open_q;
  logic [3:0] open_d;
  assign sel = !chip_select_n;
  assign nop = sel && row_strobe_n && column_strobe_n && write_select_n;
  assign act = sel && !row_strobe_n && column_strobe_n && write_select_n;
  assign pre = sel && !row_strobe_n && column_strobe_n && !write_select_n;
  assign rw = sel && row_strobe_n && !column_strobe_n;
  assign mrs = sel && !row_strobe_n && !column_strobe_n && !write_select_n;
  assign rf = sel && !row_strobe_n && !column_strobe_n && write_select_n;
  // Only commands after a high gate count; suspended edges are ignored
  always_comb begin
    cke_d = clock_gate_enable;
    open_d = open_q;
    if (cke_q && act) open_d[bank_select] = 1'b1;
    if (cke_q && pre && !address_pins[10]) open_d[bank_select] = 1'b0;
    if (cke_q && pre && address_pins[10]) open_d = 4'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cke_q <= 1'b1;
      open_q <= 4'h0;
    end else begin
      cke_q <= cke_d;
      open_q <= open_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_masked;
    (byte_lane_masks == 2'b11) [*4];
  endsequence
  sequence s_lane0_out;
    byte_lane_masks[0] [*4] ##0 dev_dq_oe;
  endsequence
  property p_cke_before; (sel && !nop) |-> cke_q; endproperty
  property p_exit_cmd; $rose(clock_gate_enable) |-> (chip_select_n || nop); endproperty
  property p_act_idle; act |-> !open_q[bank_select]; endproperty
  property p_rw_active; rw |-> open_q[bank_select]; endproperty
  property p_mrs_idle; mrs |-> open_q == 4'h0; endproperty
  property p_ref_idle; rf |-> open_q == 4'h0; endproperty
  property p_mask_oe; s_masked |-> !dev_dq_oe; endproperty
  property p_lane_zero; s_lane0_out |-> dev_dq_out[7:0] == 8'h00; endproperty
  property p_no_clash; !(host_dq_oe && dev_dq_oe); endproperty
  a_cke_before: assert property (p_cke_before) else $error("gate low before command");
  a_exit_cmd: assert property (p_exit_cmd) else $error("bad command on gate rise");
  a_act_idle: assert property (p_act_idle) else $error("row open to open bank");
  a_rw_active: assert property (p_rw_active) else $error("access to idle bank");
  a_mrs_idle: assert property (p_mrs_idle) else $error("mode set with bank open");
  a_ref_idle: assert property (p_ref_idle) else $error("refresh with bank open");
  a_mask_oe: assert property (p_mask_oe) else $error("masked read drives pins");
  a_lane_zero: assert property (p_lane_zero) else $error("masked lane not zero");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
endmodule : sdc_monitor

// >>> tb/sdram_command_decoder_bench.sv
/*
  Bench joining controller and device ends over one link.
  Assumes the core header, package and interface are compiled first.
*/
`timescale 1ns/10ps
module sdram_command_decoder_bench;
  import sdc_pkg::*;
  // ----------------------------------------
  // Stimulus, observed outputs, instances
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  sdc_cmd_type req_cmd = SDC_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic req_cke = 1'b1;
  logic [1:0] req_mask = 2'h3;
  logic [15:0] req_wdata = 16'h0000;
  logic req_drive = 1'b0;
  logic [15:0] rd_data;
  logic [15:0] read_data = 16'h0000;
  logic read_valid = 1'b0;
  logic burst_done = 1'b0;
  logic [3:0] bank_active;
  sdc_pwr_type power_state;
  logic burst_running;
  logic [14:0] mode_word;
  logic [8:0] last_column;
  logic auto_precharge;
  logic [15:0] write_data;
  logic [1:0] write_lanes;
  int failures = 0;
  int tests_run = 0;
  sdc_link_if sdc_link_if_inst ();
  sdc_host sdc_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(sdc_link_if_inst),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_cke(req_cke), .req_mask(req_mask), .req_wdata(req_wdata),
    .req_drive(req_drive), .rd_data(rd_data));
  sdc_device sdc_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(sdc_link_if_inst),
    .bank_active(bank_active), .power_state(power_state), .burst_running(burst_running),
    .mode_word(mode_word), .last_column(last_column), .auto_precharge(auto_precharge),
    .write_data(write_data), .write_lanes(write_lanes), .read_data(read_data),
    .read_valid(read_valid), .burst_done(burst_done));
  sdc_monitor sdc_monitor_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .chip_select_n(sdc_link_if_inst.chip_select_n),
    .row_strobe_n(sdc_link_if_inst.row_strobe_n),
    .column_strobe_n(sdc_link_if_inst.column_strobe_n),
    .write_select_n(sdc_link_if_inst.write_select_n),
    .clock_gate_enable(sdc_link_if_inst.clock_gate_enable),
    .bank_select(sdc_link_if_inst.bank_select), .address_pins(sdc_link_if_inst.address_pins),
    .byte_lane_masks(sdc_link_if_inst.byte_lane_masks),
    .host_dq_oe(sdc_link_if_inst.host_dq_oe), .dev_dq_out(sdc_link_if_inst.dev_dq_out),
    .dev_dq_oe(sdc_link_if_inst.dev_dq_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chk_pwr(input sdc_pwr_type got, input sdc_pwr_type exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: power state %0d want %0d", $time, got, exp);
    end
  endtask : chk_pwr
  task wait_e(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : wait_e
  // Request held through n taken edges; valid stays up for chaining
  task req(input sdc_cmd_type c, input logic [1:0] b, input logic [12:0] a,
    input logic k, input logic [1:0] m, input int n);
    int i;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_cke = k;
    req_mask = m;
    req_valid = 1'b1;
    #2;
    for (i = 0; i < 8 && req_ready !== 1'b1; i++) wait_e(1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : req
  // One command, then three edges; device state shows it after the second
  task go(input sdc_cmd_type c, input logic [1:0] b, input logic [12:0] a,
    input logic [1:0] m);
    req(c, b, a, 1'b1, m, 1);
    req_valid = 1'b0;
    wait_e(3);
  endtask : go
  task end_burst();
    burst_done = 1'b1;
    wait_e(1);
    burst_done = 1'b0;
    wait_e(2);
  endtask : end_burst
  task results();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // ----------------------------------------
  // Scenarios and main sequence
  // ----------------------------------------
  task t_banks();
    go(SDC_MRS, 2'h2, 13'h0123, 2'h3);
    chk(mode_word, 15'h4123);
    go(SDC_ACT, 2'h1, 13'h1abc, 2'h3);
    chk(bank_active, 4'h2);
    go(SDC_ACT, 2'h2, 13'h0001, 2'h3);
    go(SDC_PRE, 2'h1, 13'h1bff, 2'h3);
    chk(bank_active, 4'h4);
    go(SDC_ACT, 2'h0, 13'h0002, 2'h3);
    go(SDC_PALL, 2'h3, 13'h0400, 2'h3);
    chk(bank_active, 4'h0);
    go(SDC_ACT, 2'h0, 13'h0010, 2'h3);
    req_cmd = SDC_ACT;
    req_valid = 1'b1;
    #2;
    chk(req_ready, 1'b0);
    wait_e(1);
    req_cmd = SDC_RD;
    req_bank = 2'h2;
    #2;
    chk(req_ready, 1'b0);
    wait_e(1);
    req_valid = 1'b0;
    wait_e(3);
    chk(bank_active, 4'h1);
    $display("banks test done");
  endtask : t_banks
  task t_data();
    int i;
    go(SDC_ACT, 2'h3, 13'h0020, 2'h3);
    req_wdata = 16'hbeef;
    req_drive = 1'b1;
    req(SDC_WR, 2'h3, 13'h05a5, 1'b1, 2'h1, 1);
    req_valid = 1'b0;
    // Data stands one more edge; the device latches the beat after the command
    wait_e(1);
    req_drive = 1'b0;
    for (i = 0; i < 6 && write_lanes === 2'h0; i++) wait_e(1);
    chk(write_lanes, 2'h2);
    chk(write_data[15:8], 8'hbe);
    chk({last_column, auto_precharge}, {9'h1a5, 1'b1});
    end_burst();
    go(SDC_RD, 2'h3, 13'h0055, 2'h0);
    chk({last_column, auto_precharge, burst_running}, {9'h055, 2'b01});
    read_data = 16'h5aa5;
    read_valid = 1'b1;
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h0, 4);
    chk(rd_data, 16'h5aa5);
    read_data = 16'h1234;
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h1, 6);
    chk(rd_data, 16'h1200);
    read_valid = 1'b0;
    go(SDC_BST, 2'h0, 13'h0000, 2'h3);
    chk(burst_running, 1'b0);
    go(SDC_PALL, 2'h0, 13'h0400, 2'h3);
    $display("data test done");
  endtask : t_data
  task t_power();
    go(SDC_REF, 2'h0, 13'h0000, 2'h3);
    chk_pwr(power_state, SDC_RUN);
    req(SDC_REF, 2'h0, 13'h0000, 1'b0, 2'h3, 1);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b0, 2'h3, 3);
    chk_pwr(power_state, SDC_SREF);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h3, 4);
    chk_pwr(power_state, SDC_RUN);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b0, 2'h3, 4);
    chk_pwr(power_state, SDC_PDOWN);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h3, 4);
    chk_pwr(power_state, SDC_RUN);
    go(SDC_ACT, 2'h0, 13'h0030, 2'h3);
    go(SDC_RD, 2'h0, 13'h0000, 2'h3);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b0, 2'h3, 4);
    chk_pwr(power_state, SDC_SUSP);
    chk(burst_running, 1'b1);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h3, 4);
    chk_pwr(power_state, SDC_RUN);
    req_valid = 1'b0;
    end_burst();
    // Gate falls with a non-quiet command, bank open, no burst
    req(SDC_BST, 2'h0, 13'h0000, 1'b0, 2'h3, 1);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b0, 2'h3, 3);
    chk_pwr(power_state, SDC_SUSP);
    req(SDC_NOP, 2'h0, 13'h0000, 1'b1, 2'h3, 4);
    chk_pwr(power_state, SDC_RUN);
    go(SDC_PALL, 2'h0, 13'h0400, 2'h3);
    $display("power test done");
  endtask : t_power
  initial begin
    #60000;
    failures++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    chk({sdc_link_if_inst.chip_select_n, sdc_link_if_inst.clock_gate_enable}, 2'h3);
    chk({bank_active, burst_running, sdc_link_if_inst.dev_dq_oe}, 6'h00);
    t_banks();
    t_data();
    t_power();
    results();
  end
endmodule : sdram_command_decoder_bench
